// ==== hw/dspd_pkg.sv ====
// Constants and types shared by the DSP datapath and addressing block
package dspd_pkg;
	// Bus and word widths
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam int DW     = 16;
	localparam int AW     = 24;
	localparam int PW     = 8;
	localparam int RAW    = 9;
	localparam int STK_N  = 6;
	localparam int NSRC   = 8;
	localparam int NSYNC  = 11;

	// Register slots (word offsets inside a bank)
	localparam logic [2:0] SLOT_CTRL  = 3'h0;
	localparam logic [2:0] SLOT_SR    = 3'h1;
	localparam logic [2:0] SLOT_ALLOC = 3'h2;
	localparam logic [2:0] SLOT_ACC   = 3'h3;
	localparam logic [2:0] SLOT_PC    = 3'h4;
	localparam logic [2:0] SLOT_PTRA  = 3'h5;
	localparam logic [2:0] SLOT_PTRB  = 3'h6;
	localparam logic [2:0] SLOT_ISR   = 3'h7;
	localparam logic [2:0] BANK_ZERO  = 3'h0;

	// Reset values and interrupt vector base
	localparam logic [15:0] ALLOC_RST = 16'h0000;
	localparam logic [6:0]  SR_RST    = 7'h00;
	localparam logic [15:0] PC_RST    = 16'h0000;
	localparam logic [15:0] IRQ_VEC   = 16'h0004;

	// Sync vector layout
	localparam int SY_UI0  = 8;
	localparam int SY_UI1  = 9;
	localparam int SY_WAIT = 10;

	// Status bit positions
	localparam int SR_S3 = 3;
	localparam int SR_S4 = 4;
	localparam int SR_S5 = 5;
	localparam int SR_S6 = 6;

	// Instruction classes from the decoder
	localparam logic [3:0] OP_NOP   = 4'h0;
	localparam logic [3:0] OP_MPY   = 4'h1;
	localparam logic [3:0] OP_MAC   = 4'h2;
	localparam logic [3:0] OP_ADDD  = 4'h3;
	localparam logic [3:0] OP_LONG  = 4'h4;
	localparam logic [3:0] OP_JUMP  = 4'h5;
	localparam logic [3:0] OP_CALL  = 4'h6;
	localparam logic [3:0] OP_RET   = 4'h7;
	localparam logic [3:0] OP_SET_GLOBAL_INT_ENABLE_OP  = 4'h8;
	localparam logic [3:0] OP_EXTRD = 4'h9;
	localparam logic [3:0] OP_EXTWR = 4'ha;

	// Pointer modification and shifter codes
	localparam logic [1:0] MOD_NONE = 2'h0;
	localparam logic [1:0] MOD_INC  = 2'h1;
	localparam logic [1:0] MOD_LDEC = 2'h2;
	localparam logic [1:0] MOD_LINC = 2'h3;
	localparam logic [1:0] PTR_SHORT = 2'h3;
	localparam logic [1:0] SH_NONE = 2'h0;
	localparam logic [1:0] SH_R1   = 2'h1;
	localparam logic [1:0] SH_R3   = 2'h2;
	localparam logic [1:0] SH_L1   = 2'h3;
	localparam logic [15:0] FRAC_MIN = 16'h8000;

	typedef enum logic [2:0] {ST_IDLE, ST_LONG2, ST_EXT_WS, ST_EXT_HOLD, ST_IRQ1, ST_IRQ2} dspd_state_t;

	typedef struct packed {
		dspd_state_t                 st;
		logic [NSYNC-1:0]            s1, s2, s3, lvl;
		logic [15:0]                 pc;
		logic [AW-1:0]               acc, p;
		logic [STK_N-1:0][15:0]      stk;
		logic [2:0]                  sp;
		logic [5:0][PW-1:0]          ptr;
		logic [6:0]                  srw;
		logic                        gie, wait_en;
		logic [15:0]                 alloc;
		logic [NSRC-1:0]             isr;
		logic [2:0]                  pend;
		logic [1:0]                  line;
		logic                        busy, ram_stb, ext_stb, ext_wr, uo0, uo1;
		logic [RAW-1:0]              ram_addr;
		logic [2:0]                  ext_addr;
		logic [15:0]                 ext_data;
		logic [APB_DW-1:0]           prdata;
		logic                        pready, pslverr;
	} dspd_regs_t;
endpackage

// ==== hw/dspd_core.sv ====
// DSP core execution datapath, interrupt routing and RAM address generation
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module dspd_core (
	// Clock and reset
	input  logic                          CORE_CLK_I,
	input  logic                          RST_I,
	// APB slave
	input  logic                          PSEL_I,
	input  logic                          PENABLE_I,
	input  logic                          PWRITE_I,
	input  logic [dspd_pkg::APB_AW-1:0]   PADDR_I,
	input  logic [dspd_pkg::APB_DW-1:0]   PWDATA_I,
	output logic [dspd_pkg::APB_DW-1:0]   PRDATA_O,
	output logic                          PREADY_O,
	output logic                          PSLVERR_O,
	// Instruction decoder side
	input  logic                          OP_VALID_I,
	input  logic [3:0]                    OP_I,
	input  logic [dspd_pkg::DW-1:0]       X_I,
	input  logic [dspd_pkg::DW-1:0]       Y_I,
	input  logic [dspd_pkg::DW-1:0]       DBUS_I,
	input  logic [1:0]                    SHIFT_SEL_I,
	input  logic [15:0]                   TARGET_I,
	input  logic                          COND_EN_I,
	input  logic                          COND_SEL_I,
	input  logic                          COND_POL_I,
	input  logic                          RAM_EN_I,
	input  logic                          DIRECT_MODE_I,
	input  logic [3:0]                    PTR_FIELD_I,
	input  logic                          BANK_BIT_I,
	input  logic [dspd_pkg::RAW-1:0]      DIR_ADDR_I,
	input  logic [2:0]                    EXT_SEL_I,
	output logic                          BUSY_O,
	output logic [15:0]                   PC_O,
	output logic [dspd_pkg::AW-1:0]       ACC_O,
	// Data RAM side
	output logic                          RAM_STB_O,
	output logic [dspd_pkg::RAW-1:0]      RAM_ADDR_O,
	// External peripheral bus
	output logic                          EXT_STB_O,
	output logic                          EXT_WR_O,
	output logic [2:0]                    EXT_REG_ADDR_LINES_O,
	output logic [15:0]                   EXT_DATA_O,
	input  logic [15:0]                   EXT_DATA_I,
	input  logic                          EXT_WAIT_I,
	// Pins
	input  logic [dspd_pkg::NSRC-1:0]     IRQ_SRC_I,
	input  logic                          USER_IN_ZERO_I,
	input  logic                          USER_IN_ONE_I,
	output logic                          USER_OUT_ZERO_O,
	output logic                          USER_OUT_ONE_O
);
	import dspd_pkg::*;

	dspd_regs_t r, n;
	logic             take, br_ok, ptr_mode, wr_ok;
	logic [NSRC-1:0]  rise, en, l2_set;
	logic [2:0]       pset, sel_idx, slot;
	logic [PW-1:0]    ptr_cur;
	logic [31:0]      p32;
	logic [AW-1:0]    alu_in;
	logic [15:0]      sr16;

	// Fractional product; -1 x -1 cannot be +1 so it folds to -1
	function automatic logic [31:0] frac_mul(input logic [15:0] a, input logic [15:0] b);
		logic signed [31:0] pr;
		pr = $signed(a) * $signed(b);
		if (a == FRAC_MIN && b == FRAC_MIN) begin
			frac_mul = {FRAC_MIN, 16'h0000};
		end else begin
			frac_mul = {pr[30:0], 1'b0};
		end
	endfunction

	// Four-way shifter between product bus and ALU
	function automatic logic [AW-1:0] shift_pb(input logic [AW-1:0] v, input logic [1:0] s);
		unique case (s)
			SH_NONE: shift_pb = v;
			SH_R1:   shift_pb = AW'($signed(v) >>> 1);
			SH_R3:   shift_pb = AW'($signed(v) >>> 3);
			SH_L1:   shift_pb = {v[AW-2:0], 1'b0};
		endcase
	endfunction

	// Post-access pointer modification; loop modes keep upper bits
	function automatic logic [PW-1:0] ptr_mod(input logic [PW-1:0] p, input logic [1:0] m, input logic [2:0] k);
		logic [PW-1:0] msk;
		msk = PW'((9'h001 << k) - 9'h001);
		unique case (m)
			MOD_NONE: ptr_mod = p;
			MOD_INC:  ptr_mod = p + 8'h01;
			MOD_LDEC: ptr_mod = (p & ~msk) | ((p - 8'h01) & msk);
			MOD_LINC: ptr_mod = (p & ~msk) | ((p + 8'h01) & msk);
		endcase
	endfunction

	// Whole next-state computation
	always_comb begin
		n = r;
		// Three-stage pin sync; a level counts once stages two and three agree
		n.s1 = {EXT_WAIT_I, USER_IN_ONE_I, USER_IN_ZERO_I, IRQ_SRC_I};
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.lvl = (r.s2 & ~(r.s2 ^ r.s3)) | (r.lvl & (r.s2 ^ r.s3));
		rise = n.lvl[NSRC-1:0] & ~r.lvl[NSRC-1:0];

		// Source routing onto the three lines
		en = r.alloc[15:8];
		pset = 3'h0;
		l2_set = rise & en;
		if (!r.alloc[3] && rise[r.alloc[2:0]] && en[r.alloc[2:0]]) begin
			pset[0] = 1'b1;
		end
		if (!r.alloc[7] && r.alloc[7:4] != r.alloc[3:0] && rise[r.alloc[6:4]] && en[r.alloc[6:4]]) begin
			pset[1] = 1'b1;
		end
		if (!r.alloc[3]) begin
			l2_set[r.alloc[2:0]] = 1'b0;
		end
		if (!r.alloc[7]) begin
			l2_set[r.alloc[6:4]] = 1'b0;
		end
		pset[2] = |l2_set;
		n.isr = r.isr | (rise & en);
		n.pend = r.pend | pset;

		// Addressing decode
		ptr_mode = !DIRECT_MODE_I && PTR_FIELD_I[1:0] != PTR_SHORT;
		sel_idx = BANK_BIT_I ? 3'(PTR_FIELD_I[1:0]) + 3'h3 : 3'(PTR_FIELD_I[1:0]);
		ptr_cur = r.ptr[sel_idx];
		p32 = frac_mul(X_I, Y_I);
		br_ok = !COND_EN_I || ((COND_SEL_I ? r.lvl[SY_UI1] : r.lvl[SY_UI0]) == COND_POL_I);
		take = 1'b0;
		alu_in = shift_pb({DBUS_I, 8'h00}, SHIFT_SEL_I);
		n.ram_stb = 1'b0;

		// Instruction sequencing
		unique case (r.st)
			ST_IDLE: begin
				if (r.gie && |r.pend) begin
					n.st = ST_IRQ1;
					if (r.pend[0]) begin
						n.line = 2'h0;
					end else if (r.pend[1]) begin
						n.line = 2'h1;
					end else begin
						n.line = 2'h2;
					end
				end else if (OP_VALID_I) begin
					take = 1'b1;
					n.pc = r.pc + 16'h0001;
					if (RAM_EN_I) begin
						n.ram_stb = 1'b1;
						if (DIRECT_MODE_I) begin
							n.ram_addr = DIR_ADDR_I;
						end else if (!ptr_mode) begin
							n.ram_addr = {BANK_BIT_I, 4'h0, r.srw[SR_S4], r.srw[SR_S3], PTR_FIELD_I[3:2]};
						end else begin
							n.ram_addr = {BANK_BIT_I, ptr_cur};
							n.ptr[sel_idx] = ptr_mod(ptr_cur, PTR_FIELD_I[3:2], r.srw[2:0]);
						end
					end
					unique case (OP_I)
						OP_MPY: n.p = p32[31:8];
						OP_MAC: begin
							n.acc = r.acc + shift_pb(r.p, SHIFT_SEL_I);
							n.p = p32[31:8];
						end
						OP_ADDD: n.acc = r.acc + alu_in;
						OP_LONG: begin
							n.acc = {DBUS_I, 8'h00};
							n.pc = r.pc + 16'h0002;
							n.st = ST_LONG2;
						end
						OP_JUMP, OP_CALL: begin
							n.pc = br_ok ? TARGET_I : r.pc + 16'h0002;
							if (OP_I == OP_CALL && br_ok && r.sp < 3'(STK_N)) begin
								n.stk[r.sp] = r.pc + 16'h0002;
								n.sp = r.sp + 3'h1;
							end
							n.st = ST_LONG2;
						end
						OP_RET: begin
							if (r.sp != 3'h0) begin
								n.pc = r.stk[r.sp - 3'h1];
								n.sp = r.sp - 3'h1;
							end
						end
						OP_SET_GLOBAL_INT_ENABLE_OP: n.gie = 1'b1;
						OP_EXTRD, OP_EXTWR: begin
							n.ext_stb = 1'b1;
							n.ext_wr = (OP_I == OP_EXTWR);
							n.ext_addr = EXT_SEL_I;
							n.ext_data = r.acc[AW-1:8];
							n.st = r.wait_en ? ST_EXT_WS : ST_EXT_HOLD;
						end
						default: begin
						end
					endcase
				end
			end
			ST_LONG2: n.st = ST_IDLE;
			ST_EXT_WS: n.st = ST_EXT_HOLD;
			ST_EXT_HOLD: begin
				// Wait pin looked at only while an external access is open
				if (!r.lvl[SY_WAIT]) begin
					n.ext_stb = 1'b0;
					if (!r.ext_wr) begin
						n.acc = {EXT_DATA_I, 8'h00};
					end
					n.st = ST_IDLE;
				end
			end
			ST_IRQ1: begin
				if (r.sp < 3'(STK_N)) begin
					n.stk[r.sp] = r.pc;
					n.sp = r.sp + 3'h1;
				end
				n.gie = 1'b0;
				n.st = ST_IRQ2;
			end
			ST_IRQ2: begin
				n.pc = IRQ_VEC + 16'(r.line);
				n.pend[r.line] = pset[r.line]; // Set wins over the entry clear
				n.st = ST_IDLE;
			end
		endcase

		// APB: one wait cycle, write lands on the edge that sees pready
		slot = PADDR_I[4:2];
		sr16 = {r.gie, 3'h0, r.lvl[SY_UI1], r.lvl[SY_UI0], 3'h0, r.srw};
		n.pready = PSEL_I && PENABLE_I && !r.pready;
		if (n.pready) begin
			n.pslverr = PADDR_I[1:0] != 2'h0 || (slot != SLOT_ISR && PADDR_I[7:5] != BANK_ZERO);
			n.prdata = 32'h0000_0000;
			if (!n.pslverr) begin
				unique case (slot)
					SLOT_CTRL:  n.prdata = {31'h0, r.wait_en};
					SLOT_SR:    n.prdata = {16'h0000, sr16};
					SLOT_ALLOC: n.prdata = {16'h0000, r.alloc};
					SLOT_ACC:   n.prdata = {8'h00, r.acc};
					SLOT_PC:    n.prdata = {13'h0000, r.sp, r.pc};
					SLOT_PTRA:  n.prdata = {8'h00, r.ptr[2], r.ptr[1], r.ptr[0]};
					SLOT_PTRB:  n.prdata = {8'h00, r.ptr[5], r.ptr[4], r.ptr[3]};
					SLOT_ISR:   n.prdata = {24'h0, r.isr};
				endcase
			end
		end
		wr_ok = PSEL_I && PENABLE_I && PWRITE_I && r.pready && !r.pslverr;
		if (wr_ok) begin
			unique case (slot)
				SLOT_CTRL:  n.wait_en = PWDATA_I[0];
				SLOT_SR:    n.srw = PWDATA_I[6:0];
				SLOT_ALLOC: n.alloc = PWDATA_I[15:0];
				SLOT_PTRA:  n.ptr[2:0] = PWDATA_I[23:0];
				SLOT_PTRB:  n.ptr[5:3] = PWDATA_I[23:0];
				SLOT_ISR:   n.isr = (r.isr & ~PWDATA_I[7:0]) | (rise & en); // W1C, new event wins
				default: begin
				end
			endcase
		end

		// Registered pin and busy outputs
		n.uo0 = ~n.srw[SR_S5];
		n.uo1 = ~n.srw[SR_S6];
		n.busy = n.st != ST_IDLE;
	end

	// State register
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.pc <= PC_RST;
			r.alloc <= ALLOC_RST;
			r.srw <= SR_RST;
			r.uo0 <= 1'b1;
			r.uo1 <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from flops
	assign PRDATA_O = r.prdata;
	assign PREADY_O = r.pready;
	assign PSLVERR_O = r.pslverr;
	assign BUSY_O = r.busy;
	assign PC_O = r.pc;
	assign ACC_O = r.acc;
	assign RAM_STB_O = r.ram_stb;
	assign RAM_ADDR_O = r.ram_addr;
	assign EXT_STB_O = r.ext_stb;
	assign EXT_WR_O = r.ext_wr;
	assign EXT_REG_ADDR_LINES_O = r.ext_addr;
	assign EXT_DATA_O = r.ext_data;
	assign USER_OUT_ZERO_O = r.uo0;
	assign USER_OUT_ONE_O = r.uo1;

	// Checks on the datapath and sequencing
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	a_mul_min_fold: assert property (take && OP_I == OP_MPY && X_I == FRAC_MIN && Y_I == FRAC_MIN |=> r.p == 24'h800000)
		else $error("minus one squared not folded");
	a_mul_half: assert property (take && OP_I == OP_MPY && X_I == 16'h4000 && Y_I == 16'h4000 |=> r.p == 24'h200000)
		else $error("fractional product wrong");
	a_user_out_inv: assert property (##1 (USER_OUT_ZERO_O == ~r.srw[SR_S5] && USER_OUT_ONE_O == ~r.srw[SR_S6]))
		else $error("user output not inverted status");
	a_call_push: assert property (take && OP_I == OP_CALL && br_ok && r.sp < 3'h6 |=> r.sp == $past(r.sp) + 3'h1 && r.stk[$past(r.sp)] == $past(r.pc) + 16'h0002)
		else $error("call did not push pc plus two");
	a_irq_entry: assert property (r.st == ST_IDLE && r.gie && |r.pend |=> r.st == ST_IRQ1 ##1 r.st == ST_IRQ2 ##1 (r.st == ST_IDLE && !r.gie))
		else $error("interrupt entry sequence wrong");
	a_line_prio: assert property (r.st == ST_IDLE && r.gie && r.pend[0] |=> r.line == 2'h0)
		else $error("first line not preferred");
	a_first_route: assert property (!r.alloc[3] && rise[r.alloc[2:0]] && en[r.alloc[2:0]] |=> r.pend[0])
		else $error("allocated source missed first line");
	a_disabled_none: assert property (r.pend == 3'h0 && (rise & en) == 8'h00 && !r.gie |=> r.pend == 3'h0)
		else $error("disabled source reached a line");
	a_loop_wrap: assert property (take && RAM_EN_I && ptr_mode && PTR_FIELD_I[3:2] == MOD_LINC && r.srw[2:0] == 3'h5
		&& ptr_cur[4:0] == 5'h1f |=> r.ptr[$past(sel_idx)] == {$past(ptr_cur[7:5]), 5'h00})
		else $error("loop increment did not wrap");
	a_old_ptr: assert property (take && RAM_EN_I && ptr_mode |=> RAM_ADDR_O[7:0] == $past(ptr_cur) && RAM_STB_O)
		else $error("access did not use unmodified pointer");
	a_long_two: assert property (take && OP_I == OP_LONG |=> BUSY_O ##1 !BUSY_O)
		else $error("long op not two cycles");
	a_ext_wait: assert property (r.st == ST_EXT_HOLD && r.lvl[SY_WAIT] |=> r.st == ST_EXT_HOLD && EXT_STB_O)
		else $error("wait pin not honoured");

	// Addressing, slot decode and sequencing checks
	a_ptr_bank: assert property (take && RAM_EN_I && ptr_mode |=> RAM_ADDR_O[RAW-1] == $past(BANK_BIT_I))
		else $error("pointer bank bit not applied");
	a_direct_addr: assert property (take && RAM_EN_I && DIRECT_MODE_I |=> RAM_ADDR_O == $past(DIR_ADDR_I))
		else $error("direct address not taken from field");
	a_short_low: assert property (take && RAM_EN_I && !ptr_mode && !DIRECT_MODE_I
		|=> RAM_ADDR_O[7:4] == 4'h0)
		else $error("short form left lowest sixteen words");
	a_isr_any_bank: assert property (PSEL_I && PENABLE_I && !r.pready && PADDR_I[4:2] == SLOT_ISR
		&& PADDR_I[1:0] == 2'h0 |=> PREADY_O && !PSLVERR_O)
		else $error("status slot refused in a bank");
	a_shared_line: assert property (!r.alloc[3] && !r.alloc[7] && rise[1] && en[1]
		&& r.alloc[2:0] != 3'h1 && r.alloc[6:4] != 3'h1 |=> r.pend[2])
		else $error("enabled source missed shared line");
	a_branch_two: assert property (take && (OP_I == OP_JUMP || OP_I == OP_CALL) |=> BUSY_O ##1 !BUSY_O)
		else $error("jump or call not two cycles");

	c_irq: cover property (r.st == ST_IRQ1 ##1 r.st == ST_IRQ2);
	c_call_ret: cover property (take && OP_I == OP_CALL ##[1:20] take && OP_I == OP_RET);
	c_ext_ws: cover property (r.st == ST_EXT_WS ##1 r.st == ST_EXT_HOLD ##1 r.lvl[SY_WAIT]);
	c_loop: cover property (take && RAM_EN_I && ptr_mode && PTR_FIELD_I[3:2] == MOD_LDEC);
endmodule // dspd_core

// ==== dv/dspd_ext_model.sv ====
// Behavioural peripheral on the core's external register bus
`timescale 1ns/1ps
module dspd_ext_model (
	// Bus from the core
	input  wire logic        clk_i,
	input  wire logic        stb_i,
	input  wire logic        wr_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [3:0]  wait_len_i,
	// Answer to the core
	output logic      [15:0] rdata_o,
	output logic             wait_o,
	output logic      [15:0] last_wr_o
);
	logic [3:0] cnt = 4'h0;
	initial begin
		wait_o = 1'b0;
		last_wr_o = 16'h0;
	end
	// Slow peripheral raises wait ahead of the access: the core hears the pin only after its synchroniser
	always @(posedge clk_i) begin
		cnt <= stb_i ? ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0) : wait_len_i;
		wait_o <= stb_i ? (cnt > 4'h1) : (wait_len_i != 4'h0);
		if (stb_i && wr_i)
			last_wr_o <= wdata_i;
	end
	// Read data stand while the strobe is up; a released bus shows the inverse
	assign rdata_o = stb_i ? {addr_i, 13'h0a5c} : ~{addr_i, 13'h0a5c};
endmodule // dspd_ext_model

// ==== dv/tb.sv ====
// Self-checking bench for the DSP datapath and addressing core
`timescale 1ns/1ps
module tb;
	import dspd_pkg::*;
	// Bench state
	logic        clk, rst, psel, pen, pwr, opv, cen, csel, cpol, ramen, dmode, bank, ui0, ui1;
	logic        pready, pslverr, busy, ram_stb, ext_stb, ext_wr, uo0, uo1, ewait;
	logic [7:0]  paddr, irq, pv;
	logic [31:0] pwdata, prdata, pw;
	logic [3:0]  opc, pfield, f, wlen;
	logic [15:0] xin, yin, dbus, tgt, pc, pc0, tv, xv, yv, edi, edo, last_wr;
	logic [1:0]  shsel;
	logic [8:0]  daddr, ram_addr, da;
	logic [2:0]  esel, eaddr, exp_sel;
	logic [6:0]  sr;
	logic [23:0] acc, exp_acc;
	logic [32:0] e;
	logic [15:0] ret_pc[6];
	logic [32:0] apb_q[$];
	logic [8:0]  ram_q[$];
	int          fail_count, num_checks, busy_n, stb_n, n, seed;

	dspd_core DUT (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .OP_VALID_I(opv), .OP_I(opc),
		.X_I(xin), .Y_I(yin), .DBUS_I(dbus), .SHIFT_SEL_I(shsel), .TARGET_I(tgt), .COND_EN_I(cen), .COND_SEL_I(csel),
		.COND_POL_I(cpol), .RAM_EN_I(ramen), .DIRECT_MODE_I(dmode), .PTR_FIELD_I(pfield), .BANK_BIT_I(bank),
		.DIR_ADDR_I(daddr), .EXT_SEL_I(esel), .BUSY_O(busy), .PC_O(pc), .ACC_O(acc), .RAM_STB_O(ram_stb),
		.RAM_ADDR_O(ram_addr), .EXT_STB_O(ext_stb), .EXT_WR_O(ext_wr), .EXT_REG_ADDR_LINES_O(eaddr),
		.EXT_DATA_O(edo), .EXT_DATA_I(edi), .EXT_WAIT_I(ewait), .IRQ_SRC_I(irq), .USER_IN_ZERO_I(ui0),
		.USER_IN_ONE_I(ui1), .USER_OUT_ZERO_O(uo0), .USER_OUT_ONE_O(uo1));

	dspd_ext_model PEER (.clk_i(clk), .stb_i(ext_stb), .wr_i(ext_wr), .addr_i(eaddr), .wdata_i(edo),
		.wait_len_i(wlen), .rdata_o(edi), .wait_o(ewait), .last_wr_o(last_wr));

	// 250 MHz core clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Fractional product, upper 24 of the 32 bits; minus one squared stays minus one
	function automatic logic [23:0] prod24(input logic [15:0] a, input logic [15:0] b);
		logic signed [31:0] m;
		m = $signed(a) * $signed(b);
		return (a == FRAC_MIN && b == FRAC_MIN) ? 24'h800000 : m[30:7];
	endfunction
	function automatic logic [23:0] shf(input logic [23:0] p, input logic [1:0] s);
		case (s)
			SH_R1: return 24'($signed(p) >>> 1);
			SH_R3: return 24'($signed(p) >>> 3);
			SH_L1: return p << 1;
			default: return p;
		endcase
	endfunction
	// Pointer update; loop modes keep the bits above the loop size
	function automatic logic [7:0] nxt(input logic [7:0] p, input logic [1:0] m, input logic [2:0] k);
		logic [7:0] msk;
		msk = (8'h1 << k) - 8'h1;
		case (m)
			MOD_INC: return p + 8'h1;
			MOD_LDEC: return (p & ~msk) | ((p - 8'h1) & msk);
			MOD_LINC: return (p & ~msk) | ((p + 8'h1) & msk);
			default: return p;
		endcase
	endfunction

	task automatic stop_test;
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// One APB transfer; the expected answer is noted for the monitor
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] ex);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		apb_q.push_back(ex);
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			fail_count++;
			stop_test();
		end
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		apb(1'b0, a, 32'h0, {1'b0, d});
	endtask
	// Offer one instruction, then count busy cycles over a short window
	task automatic op(input logic [3:0] c);
		@(posedge clk);
		opv <= 1'b1;
		opc <= c;
		@(posedge clk);
		opv <= 1'b0;
		busy_n = 0;
		repeat (4) begin
			@(posedge clk);
			if (busy === 1'b1)
				busy_n++;
		end
	endtask

	// Monitor pops the oldest note whenever a result appears
	always @(posedge clk) begin
		if (psel && pen && pready === 1'b1) begin
			e = (apb_q.size() != 0) ? apb_q.pop_front() : 33'h1deadbeef;
			chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
			if (!pwr)
				chk("prdata", e[31:0], prdata);
		end
		if (ram_stb === 1'b1)
			chk("ram_addr", (ram_q.size() != 0) ? {23'h0, ram_q.pop_front()} : 32'hffff, {23'h0, ram_addr});
		if (ext_stb === 1'b1) begin
			stb_n++;
			chk("ext_addr", {29'h0, exp_sel}, {29'h0, eaddr});
		end
	end

	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		stop_test();
	end

	initial begin
		seed = 66;
		{psel, pen, pwr, opv, cen, csel, cpol, ramen, dmode, bank, ui1} = '0;
		{paddr, pwdata, opc, pfield, wlen, xin, yin, tgt, shsel, daddr, esel, exp_sel, irq} = '0;
		dbus = 16'h0;
		ui0 = 1'b1;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		chk("user_out_rst", 32'h3, {30'h0, uo1, uo0});
		// Pin synchroniser needs a few edges before the status shows the input
		repeat (4) @(posedge clk);
		rd(8'h04, 32'h400);
		rd(8'h08, 32'h0);
		apb(1'b0, 8'h01, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 8'h24, 32'h1, {1'b1, 32'h0});
		rd(8'hfc, 32'h0);
		// Accumulate through every shifter code; minus one squared first
		exp_acc = 24'h0;
		for (int i = 0; i < 12; i++) begin
			xv = (i == 0) ? FRAC_MIN : {4'h0, 12'($random(seed))};
			yv = (i == 0) ? FRAC_MIN : {4'h0, 12'($random(seed))};
			shsel <= i[1:0];
			xin <= xv;
			yin <= yv;
			op(OP_MAC);
			chk("mac_busy", 32'h0, 32'(busy_n));
			xin <= 16'h0;
			yin <= 16'h0;
			op(OP_MAC);
			exp_acc = exp_acc + shf(prod24(xv, yv), i[1:0]);
			chk("acc", {8'h0, exp_acc}, {8'h0, acc});
		end
		// Data bus onto the upper product bus bits, then a long immediate load
		for (int i = 0; i < 4; i++) begin
			tv = 16'($random(seed));
			dbus <= tv;
			shsel <= i[1:0];
			op(OP_ADDD);
			exp_acc = exp_acc + shf({tv, 8'h00}, i[1:0]);
			chk("addd_acc", {8'h0, exp_acc}, {8'h0, acc});
		end
		pc0 = pc;
		op(OP_LONG);
		chk("long_busy", 32'h1, 32'(busy_n));
		chk("long_acc", {8'h0, dbus, 8'h00}, {8'h0, acc});
		chk("long_pc", {16'h0, pc0 + 16'h2}, {16'h0, pc});
		// Six nested calls unwind in reverse
		for (int j = 0; j < 6; j++) begin
			ret_pc[j] = pc + 16'h2;
			tv = 16'($random(seed));
			tgt <= tv;
			op(OP_CALL);
			chk("call_busy", 32'h1, 32'(busy_n));
			chk("call_pc", {16'h0, tv}, {16'h0, pc});
		end
		for (int j = 5; j >= 0; j--) begin
			op(OP_RET);
			chk("ret_pc", {16'h0, ret_pc[j]}, {16'h0, pc});
		end
		// Conditional jumps and calls on both user pins and both polarities
		cen <= 1'b1;
		for (int j = 0; j < 8; j++) begin
			tv = 16'($random(seed));
			pc0 = pc;
			csel <= j[0];
			cpol <= j[1];
			tgt <= tv;
			op(j[2] ? OP_CALL : OP_JUMP);
			chk("cond_pc", {16'h0, ((j[0] ? ui1 : ui0) == j[1]) ? tv : pc0 + 16'h2}, {16'h0, pc});
			if (j[2] && (j[0] ? ui1 : ui0) == j[1]) begin
				op(OP_RET);
				chk("cond_ret", {16'h0, pc0 + 16'h2}, {16'h0, pc});
			end
		end
		cen <= 1'b0;
		// Sources 3 and 5 own the top lines, 1 and 4 share the last, 7 is disabled
		wr(8'h08, 32'h7f53);
		irq <= 8'h3a;
		repeat (2) @(posedge clk);
		irq <= 8'h00;
		repeat (8) @(posedge clk);
		rd(8'h7c, 32'h3a);
		for (int j = 0; j < 3; j++) begin
			pc0 = pc;
			op(OP_SET_GLOBAL_INT_ENABLE_OP);
			chk("irq_busy", 32'h2, 32'(busy_n));
			chk("irq_vec", {16'h0, IRQ_VEC + 16'(j)}, {16'h0, pc});
			op(OP_RET);
			chk("irq_ret", {16'h0, pc0 + 16'h1}, {16'h0, pc});
		end
		wr(8'h1c, 32'hff);
		op(OP_SET_GLOBAL_INT_ENABLE_OP);
		pc0 = pc;
		irq <= 8'h80;
		repeat (12) @(posedge clk);
		irq <= 8'h00;
		chk("irq_off", {16'h0, pc0}, {15'h0, busy, pc});
		// Pointer, short-form and direct accesses over both banks
		ramen <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			sr = 7'($random(seed));
			pw = $random(seed);
			f = {i[1:0], i[3] ? 2'b11 : 2'(i % 3)};
			if (i == 3) begin
				sr[2:0] = 3'h5;
				pw[7:0] = 8'ha9;
			end
			wr(8'h04, {25'h0, sr});
			wr(i[2] ? 8'h18 : 8'h14, {8'h0, pw[23:0]});
			repeat (2) @(posedge clk);
			chk("user_out", {30'h0, ~sr[6], ~sr[5]}, {30'h0, uo1, uo0});
			pv = pw[8 * f[1:0] +: 8];
			pfield <= f;
			bank <= i[2];
			dmode <= (i == 15);
			{xin, yin} <= i[0] ? {FRAC_MIN, FRAC_MIN} : 32'h4000_4000;
			for (int k = 0; k < ((i == 3) ? 24 : 6); k++) begin
				da = 9'($random(seed));
				daddr <= da;
				if (i == 15)
					ram_q.push_back(da);
				else if (f[1:0] == 2'b11)
					ram_q.push_back({i[2], 4'h0, sr[4], sr[3], f[3:2]});
				else begin
					ram_q.push_back({i[2], pv});
					pv = nxt(pv, f[3:2], sr[2:0]);
				end
				op(OP_MPY);
			end
			if (f[1:0] != 2'b11) begin
				pw[8 * f[1:0] +: 8] = pv;
				rd(i[2] ? 8'h18 : 8'h14, {8'h0, pw[23:0]});
			end
		end
		ramen <= 1'b0;
		dmode <= 1'b0;
		// External access: plain, programmed wait state, then pin stretch
		for (int j = 0; j < 3; j++) begin
			wr(8'h00, {31'h0, j != 0});
			wlen <= (j == 2) ? 4'h4 : 4'h0;
			exp_sel = 3'(j + 5);
			esel <= exp_sel;
			stb_n = 0;
			// Give the wait pin time through the synchroniser before the access
			repeat (4) @(posedge clk);
			op(j == 1 ? OP_EXTWR : OP_EXTRD);
			n = 0;
			while (ext_stb !== 1'b0 && n < 40) begin
				@(posedge clk);
				n++;
			end
			if (n >= 40) begin
				fail_count++;
				stop_test();
			end
			@(posedge clk);
			if (j == 1)
				chk("ext_wdata", {16'h0, acc[23:8]}, {16'h0, last_wr});
			else
				chk("ext_rdata", {16'h0, exp_sel, 13'h0a5c}, {16'h0, acc[23:8]});
			chk("ext_len", 32'h1, {31'h0, stb_n == 1 + j || (j == 2 && stb_n > 4 && stb_n < 12)});
		end
		stop_test();
	end
endmodule // tb
